// ---- rtl/global_cfg_pkg.sv ----
// Package for the global configuration register bank and its host.
// Assumes one synchronous clock and an 8-bit configuration path.
package global_cfg_pkg;
	// Register indices
	localparam logic [7:0] idx_valid_cycle_flag    = 8'h00;
	localparam logic [7:0] idx_config_lock         = 8'h01;
	localparam logic [7:0] idx_port_power_control  = 8'h02;
	localparam logic [7:0] idx_last_lockable_register = 8'h39;
	// Reset values on main-supply power-on reset
	localparam logic [7:0] por_valid_cycle_flag    = 8'h20;
	localparam logic [7:0] por_config_lock         = 8'h98;
	localparam logic [7:0] por_port_power_control  = 8'h00;
	// Fixed read-only patterns and writable masks
	localparam logic [7:0] fixed_valid_cycle_flag  = 8'h20;
	localparam logic [7:0] wmask_valid_cycle_flag  = 8'h88;
	localparam logic [7:0] fixed_config_lock       = 8'h10;
	localparam logic [7:0] wmask_config_lock       = 8'h8c;
	localparam logic [7:0] wmask_port_power_control = 8'h8e;
	// Field positions
	localparam int valid_flag_bit       = 7;
	localparam int valid_reserved_bit   = 3;
	localparam int lock_bit             = 7;
	localparam int lock_reserved_bit    = 2;
	localparam int power_port_three_bit = 1;
	localparam int power_port_four_bit  = 2;
	localparam int power_port_one_bit   = 3;
	localparam int power_port_two_bit   = 7;
	// Base address below which decoding is disabled
	localparam logic [15:0] min_base_address = 16'h0100;
	// Host command port offsets (host-side registers)
	localparam logic [1:0] host_reg_index  = 2'h0;
	localparam logic [1:0] host_reg_data   = 2'h1;
	localparam logic [1:0] host_reg_status = 2'h2;
	// Host transfer engine states
	typedef enum logic [1:0] {
		host_idle,
		host_wait_read
	} host_state_type;
endpackage

// ---- rtl/cfg_link_if.sv ----
// Interface carrying configuration cycles between host and device.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/1ps
interface cfg_link_if;
	logic       config_state;  // Device in configuration state
	logic       index_write;   // Load config_index_register
	logic       data_write;    // Write data to indexed register
	logic       data_read;     // Read indexed register
	logic [7:0] wdata;
	logic [7:0] rdata;         // Valid in cycle after data_read
	modport device (
		input  config_state,
		input  index_write,
		input  data_write,
		input  data_read,
		input  wdata,
		output rdata
	);
	modport host (
		output config_state,
		output index_write,
		output data_write,
		output data_read,
		output wdata,
		input  rdata
	);
endinterface

// ---- rtl/base_decode_gate.sv ----
// Address-decode gate for one logical device.
// Assumes base address is a stable configuration value.
`timescale 1ns/1ps
module base_decode_gate
	import global_cfg_pkg::*;
(
	// Configuration
	input  wire logic [15:0] base_address,
	// Result
	output logic             decode_enable
);
	// Decode stays active regardless of power-down
	assign decode_enable = (base_address >= min_base_address);
endmodule // base_decode_gate

// ---- rtl/global_cfg_regs.sv ----
// Device end: global configuration registers 00h to 02h.
// Assumes the host drives the link synchronously to sys_clk.
`timescale 1ns/1ps
module global_cfg_regs
	import global_cfg_pkg::*;
(
	// Clock and resets
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        hard_reset,
	// Configuration link
	cfg_link_if.device       link,
	// Base addresses of the four ports
	input  wire logic [15:0] port_one_base,
	input  wire logic [15:0] port_two_base,
	input  wire logic [15:0] port_three_base,
	input  wire logic [15:0] port_four_base,
	// Power, lock and decode outputs
	output logic             serial_port_one_power,
	output logic             serial_port_two_power,
	output logic             serial_port_three_power,
	output logic             serial_port_four_power,
	output logic             infrared_serial_engine_power,
	output logic             global_register_lock_bit,
	output logic [3:0]       port_decode_enable
);
	import global_cfg_pkg::*;

	logic [7:0] config_index_register;
	logic [7:0] valid_cycle_flag;
	logic [7:0] config_lock;
	logic [7:0] port_power_control;
	logic       access_ok;
	logic       do_write;
	logic [7:0] next_rdata;

	// Access gate: config state and lock open for 00h-39h
	assign access_ok = link.config_state && global_register_lock_bit
		&& (config_index_register <= idx_last_lockable_register);
	assign do_write = link.data_write && access_ok;

	// Index register load
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_index_register <= 8'h00;
		end else if (link.config_state && link.index_write) begin
			config_index_register <= link.wdata;
		end
	end

	// Valid-cycle register; only bits 7 and 3 stored
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_cycle_flag <= por_valid_cycle_flag;
		end else if (hard_reset) begin
			valid_cycle_flag[valid_reserved_bit] <= 1'b0;
		end else if (do_write && config_index_register == idx_valid_cycle_flag) begin
			valid_cycle_flag <= (link.wdata & wmask_valid_cycle_flag)
				| fixed_valid_cycle_flag;
		end
	end

	// Lock register; lock bit only clears by software
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_lock <= por_config_lock;
		end else if (hard_reset) begin
			config_lock[lock_bit]          <= 1'b1;
			config_lock[lock_reserved_bit] <= 1'b0;
		end else if (do_write && config_index_register == idx_config_lock) begin
			config_lock <= ((link.wdata & wmask_config_lock)
				| fixed_config_lock)
				& {link.wdata[lock_bit] & config_lock[lock_bit], 7'h7f};
		end
	end

	// Port power register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_power_control <= por_port_power_control;
		end else if (hard_reset) begin
			port_power_control <= por_port_power_control;
		end else if (do_write
			&& config_index_register == idx_port_power_control) begin
			port_power_control <= link.wdata & wmask_port_power_control;
		end
	end

	// Read mux; blocked reads return zero
	always_comb begin
		next_rdata = 8'h00;
		if (link.data_read && access_ok) begin
			case (config_index_register)
				idx_valid_cycle_flag:   next_rdata = valid_cycle_flag;
				idx_config_lock:        next_rdata = config_lock;
				idx_port_power_control: next_rdata = port_power_control;
				default:                next_rdata = 8'h00;
			endcase
		end
	end

	// Read data registered for the following cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.rdata <= 8'h00;
		end else begin
			link.rdata <= next_rdata;
		end
	end

	// Power outputs from register bits
	assign serial_port_three_power = port_power_control[power_port_three_bit];
	assign serial_port_four_power  = port_power_control[power_port_four_bit];
	assign serial_port_one_power   = port_power_control[power_port_one_bit];
	assign serial_port_two_power   = port_power_control[power_port_two_bit];
	assign infrared_serial_engine_power = port_power_control[power_port_two_bit];
	assign global_register_lock_bit = config_lock[lock_bit];

	// Address decode per port, independent of power
	base_decode_gate u_dec_one (
		.base_address  (port_one_base),
		.decode_enable (port_decode_enable[0])
	);
	base_decode_gate u_dec_two (
		.base_address  (port_two_base),
		.decode_enable (port_decode_enable[1])
	);
	base_decode_gate u_dec_three (
		.base_address  (port_three_base),
		.decode_enable (port_decode_enable[2])
	);
	base_decode_gate u_dec_four (
		.base_address  (port_four_base),
		.decode_enable (port_decode_enable[3])
	);
endmodule // global_cfg_regs

// ---- rtl/global_cfg_host.sv ----
// Host end: turns software port accesses into configuration cycles.
// Assumes software sequences pin setup before setting power bits.
`timescale 1ns/1ps
module global_cfg_host
	import global_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Software port
	input  wire logic [1:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_write,
	input  wire logic       sw_read,
	output logic [7:0]      sw_rdata,
	// Configuration state request
	input  wire logic       enter_config,
	// Link
	cfg_link_if.host        link
);
	import global_cfg_pkg::*;

	host_state_type state;
	logic           rd_pending;

	// Configuration state level
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			link.config_state <= 1'b0;
		end else begin
			link.config_state <= enter_config;
		end
	end

	// Link strobes issued straight from software strobes
	assign link.index_write = sw_write && sw_addr == host_reg_index;
	assign link.data_write  = sw_write && sw_addr == host_reg_data;
	assign link.data_read   = sw_read && sw_addr == host_reg_data;
	assign link.wdata       = sw_wdata;

	// Track outstanding read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= host_idle;
		end else begin
			case (state)
				host_idle:      state <= link.data_read ? host_wait_read : host_idle;
				host_wait_read: state <= link.data_read ? host_wait_read : host_idle;
				default:        state <= host_idle;
			endcase
		end
	end
	assign rd_pending = (state == host_wait_read);

	// Status read returns config-state flag
	logic status_pending;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_pending <= 1'b0;
		end else begin
			status_pending <= sw_read && sw_addr == host_reg_status;
		end
	end

	// Read data in the cycle after the strobe
	always_comb begin
		sw_rdata = 8'h00;
		if (rd_pending) begin
			sw_rdata = link.rdata;
		end else if (status_pending) begin
			sw_rdata = {7'h00, link.config_state};
		end
	end
endmodule // global_cfg_host

// ---- tb/global_cfg_link_sva.sv ----
// Checker for the link between host end and register bank.
// Assumes one clock; sees link signals and both resets.
`timescale 1ns/1ps
module global_cfg_link_check
	import global_cfg_pkg::*;
(
	// Clock and resets
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       hard_reset,
	// Link
	input wire logic       config_state,
	input wire logic       index_write,
	input wire logic       data_write,
	input wire logic       data_read,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata
);
	logic [7:0] idx;
	logic       lock;
	logic       open;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Mirror of the index register
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			idx <= 8'h00;
		else if (index_write && config_state)
			idx <= wdata;
	end
	// Mirror of the lock bit; software can only clear it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			lock <= 1'b1;
		else if (hard_reset)
			lock <= 1'b1;
		else if (open && data_write && idx == idx_config_lock && !wdata[7])
			lock <= 1'b0;
	end
	// Access allowed for the current index
	assign open = config_state && lock && idx <= idx_last_lockable_register;
	property p_idle_zero;
		!data_read |=> rdata == 8'h00;
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("rdata not zero after idle cycle");
	property p_cfg_gate;
		data_read && !config_state |=> rdata == 8'h00;
	endproperty
	a_cfg_gate: assert property (p_cfg_gate)
		else $error("read outside config state returned data");
	property p_closed_zero;
		data_read && !open |=> rdata == 8'h00;
	endproperty
	a_closed_zero: assert property (p_closed_zero)
		else $error("blocked read returned data");
	property p_valid_ro;
		data_read && open && idx == idx_valid_cycle_flag
			|=> rdata[6:4] == 3'h2 && rdata[2:0] == 3'h0;
	endproperty
	a_valid_ro: assert property (p_valid_ro)
		else $error("valid register fixed bits wrong");
	property p_lock_ro;
		data_read && open && idx == idx_config_lock
			|=> rdata[6:4] == 3'h1 && rdata[1:0] == 2'h0;
	endproperty
	a_lock_ro: assert property (p_lock_ro)
		else $error("lock register fixed bits wrong");
	property p_lock_read;
		data_read && open && idx == idx_config_lock |=> rdata[7] == $past(lock);
	endproperty
	a_lock_read: assert property (p_lock_read)
		else $error("lock bit readback wrong");
	property p_power_ro;
		data_read && open && idx == idx_port_power_control
			|=> rdata[6:4] == 3'h0 && !rdata[0];
	endproperty
	a_power_ro: assert property (p_power_ro)
		else $error("power register fixed bits wrong");
	property p_spare;
		data_read && open && idx > idx_port_power_control |=> rdata == 8'h00;
	endproperty
	a_spare: assert property (p_spare)
		else $error("spare index returned data");
endmodule // global_cfg_link_check

// ---- tb/global_config_lock_power_regs_test.sv ----
// Testbench joining host end and register bank over the link.
// Assumes the host software port protocol.
`timescale 1ns/1ps
module global_config_lock_power_regs_test;
	import global_cfg_pkg::*;
	logic        sys_clk = 1'b0, rst_n = 1'b0, hard_reset = 1'b0;
	logic        sw_write = 1'b0, sw_read = 1'b0, enter_config = 1'b0;
	logic [1:0]  sw_addr = 2'h0;
	logic [7:0]  sw_wdata = 8'h00, sw_rdata, d;
	logic [15:0] b1 = 16'h00ff, b2 = 16'h0100, b3 = 16'h0000, b4 = 16'hffff;
	logic        p1, p2, p3, p4, pir, lk;
	logic [3:0]  dec;
	int          num_errors = 0, num_checks = 0;
	cfg_link_if link ();
	global_cfg_host global_cfg_host_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
		.sw_read(sw_read), .sw_rdata(sw_rdata),
		.enter_config(enter_config), .link(link.host));
	global_cfg_regs global_cfg_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.hard_reset(hard_reset), .link(link.device), .port_one_base(b1),
		.port_two_base(b2), .port_three_base(b3), .port_four_base(b4),
		.serial_port_one_power(p1), .serial_port_two_power(p2),
		.serial_port_three_power(p3), .serial_port_four_power(p4),
		.infrared_serial_engine_power(pir), .global_register_lock_bit(lk),
		.port_decode_enable(dec));
	global_cfg_link_check global_cfg_link_check_inst (.sys_clk(sys_clk),
		.rst_n(rst_n), .hard_reset(hard_reset),
		.config_state(link.config_state), .index_write(link.index_write),
		.data_write(link.data_write), .data_read(link.data_read),
		.wdata(link.wdata), .rdata(link.rdata));
	// Clock, 20 ns period
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	// Compare and count
	task automatic chk(input string n, input logic [7:0] e, g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// One software write with a gap cycle
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		sw_addr <= a;
		sw_wdata <= v;
		sw_write <= 1'b1;
		@(posedge sys_clk);
		sw_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	// Indexed register write
	task automatic put(input logic [7:0] i, v);
		wr(2'h0, i);
		wr(2'h1, v);
	endtask
	// Raw software read, data sampled mid-cycle
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		sw_addr <= a;
		sw_read <= 1'b1;
		@(posedge sys_clk);
		sw_read <= 1'b0;
		@(negedge sys_clk);
		v = sw_rdata;
		@(posedge sys_clk);
	endtask
	// Indexed register read
	task automatic get(input logic [7:0] i, output logic [7:0] v);
		wr(2'h0, i);
		rd(2'h1, v);
	endtask
	// Read and compare
	task automatic rc(input string n, input logic [7:0] i, e);
		get(i, d);
		chk(n, e, d);
	endtask
	// Outputs packed as ir, one, two, three, four, lock
	function automatic logic [7:0] outs();
		return {2'h0, pir, p1, p2, p3, p4, lk};
	endfunction
	// Power-on values
	task automatic t_reset();
		rc("valid", 8'h00, 8'h20);
		rc("lock", 8'h01, 8'h98);
		rc("power", 8'h02, 8'h00);
		chk("outs", 8'h01, outs());
	endtask
	// Field writes, fixed bits and port mapping
	task automatic t_bits();
		logic [7:0] m [4] = '{8'h08, 8'h80, 8'h02, 8'h04};
		logic [7:0] e [4] = '{8'h11, 8'h29, 8'h05, 8'h03};
		put(8'h00, 8'hf7);
		rc("valid", 8'h00, 8'ha0);
		put(8'h01, 8'hfb);
		rc("lock", 8'h01, 8'h98);
		for (int i = 0; i < 4; i++) begin
			put(8'h02, m[i]);
			chk("port", e[i], outs());
		end
		put(8'h02, 8'hff);
		rc("power", 8'h02, 8'h8e);
		chk("decode", 8'h0a, {4'h0, dec});
		rc("spare", 8'h05, 8'h00);
		rc("high", 8'h40, 8'h00);
	endtask
	// Accesses outside configuration state
	task automatic t_cfg();
		wr(2'h0, 8'h02);
		enter_config <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rd(2'h2, d);
		chk("status", 8'h00, d);
		put(8'h02, 8'h00);
		rc("nocfg", 8'h02, 8'h00);
		enter_config <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd(2'h2, d);
		chk("status", 8'h01, d);
		rc("power", 8'h02, 8'h8e);
	endtask
	// Lock, relock attempt, hard reset
	task automatic t_lock();
		put(8'h01, 8'h18);
		rc("locked", 8'h02, 8'h00);
		put(8'h02, 8'h00);
		put(8'h01, 8'h98);
		chk("outs", 8'h3e, outs());
		hard_reset <= 1'b1;
		@(posedge sys_clk);
		hard_reset <= 1'b0;
		@(posedge sys_clk);
		chk("outs", 8'h01, outs());
		chk("decode", 8'h0a, {4'h0, dec});
		b1 <= 16'h0100;
		b2 <= 16'h00ff;
		@(posedge sys_clk);
		chk("decode", 8'h09, {4'h0, dec});
		rc("lock", 8'h01, 8'h98);
		get(8'h00, d);
		chk("valid", 8'ha0, d);
	endtask
	// Verdict
	task automatic results();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		enter_config <= 1'b1;
		repeat (2) @(posedge sys_clk);
		t_reset();
		t_bits();
		t_cfg();
		t_lock();
		results();
	end
	// Hang guard
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		results();
	end
endmodule // global_config_lock_power_regs_test
